//--- pwm_gen_pkg.sv
// Constants, register map and types for the three-phase PWM generator with chopper
package pwm_gen_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned AXI_AW = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PWM_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CHOP = 8'h08;
    localparam logic [7:0] ADDR_POLARITY = 8'h0c;
    localparam logic [7:0] ADDR_REPEAT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_CMP_BASE = 8'h20;
    localparam logic [7:0] CMP_STRIDE = 8'h08;
    localparam logic [7:0] CMP_HIGH_OFS = 8'h04;

    // Field positions
    localparam int unsigned CTRL_CKE_BIT = 0;
    localparam int unsigned CTRL_PCN_BIT = 1;
    localparam int unsigned CTRL_DTE_BIT = 2;
    localparam int unsigned STAT_IRQ_BIT = 0;
    localparam int unsigned STAT_DIR_BIT = 1;
    localparam int unsigned STAT_CNT_LSB = 16;

    // Reset values
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hfff8;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam int unsigned NUM_CMP = 4;
    localparam int unsigned NUM_CH = 6;
    localparam int unsigned CMP_LSB = 3;
    localparam logic [12:0] CMP13_MAX = 13'h1fff;

    // Chopper frequencies in Hz, one per selector code
    localparam int unsigned CHOP_FREQ_HZ [8] = '{100_000, 200_000, 400_000, 500_000,
                                                 800_000, 1_000_000, 1_333_333, 2_000_000};

    typedef enum logic {CNT_UP, CNT_DOWN} cnt_dir_type;

    typedef struct packed {
        logic [2:0] full_duty_force;
        logic byte_mode_sel;
        logic center_align_sel;
        logic [2:0] pwm_prescale_sel;
    } pwm_ctrl_type;

    typedef struct packed {
        logic [2:0] chop_freq_sel;
        logic [1:0] chop_channel_sel;
    } chop_cfg_type;

    typedef struct packed {
        logic deadtime_enable_bit;
        logic phase_count_sel;
        logic clock_enable;
    } gen_ctrl_type;

    // Half period of the chop carrier in clocks, rounded down, never zero
    function automatic logic [10:0] chop_half(input logic [2:0] sel);
        int unsigned h;
        h = CLK_HZ / (2 * CHOP_FREQ_HZ[sel]);
        if (h == 0) begin
            h = 1;
        end
        return h[10:0];
    endfunction : chop_half

    // Left-aligned 16-bit value rounded to its 13 significant bits
    function automatic logic [12:0] round13(input logic [15:0] v);
        logic [13:0] s;
        s = {1'b0, v[15:CMP_LSB]} + {13'h0000, v[CMP_LSB-1]};
        return s[13] ? CMP13_MAX : s[12:0];
    endfunction : round13
endpackage : pwm_gen_pkg

//--- pwm_chopper_gen.sv
// Three-phase PWM generator with preload compares, prescaler and chopper, AXI4-Lite slave
//
// How it works
// - two-bit selector picks chopped side
// - eight chop frequencies from 3-bit selector
// - single-phase, no deadtime: polarity register sets side
// - single-phase complementary: fixed pairs, chop selected side
// - route phase U only or all three
// - one 12-bit counter, three 13-bit compares
// - 12-bit carrier period sets turning point
// - preloads copy to active only at update or start
// - prescaler divides clock by 1 to 8
// - prescale value buffered until update event
// - alignment bit selects center or edge
// - compare counter zero-extended to 13 bits
// - center mode counts up then down
// - center: low on up match, high down
// - compare over period high, zero low
// - edge mode clears at period, restarts
// - low byte then high byte commits
// - 8-bit mode full-duty bits, cleared on update
// - reads return preload contents
// - 13 left-aligned bits, rounded on load
// - transfer on over/underflow with repeat zero
// - counter held zero while clock disabled; start forces transfer
// - update flag raised at each update
`timescale 1ns/10ps
module pwm_chopper_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [pwm_gen_pkg::AXI_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [pwm_gen_pkg::AXI_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic [2:0] phase_out,
    output logic [pwm_gen_pkg::NUM_CH-1:0] motor_drive_output,
    output logic update_pulse
);
    import pwm_gen_pkg::*;

    logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic wr_do, wr_en, wr_hit;

    gen_ctrl_type gen_q;
    pwm_ctrl_type ctrl_pre_q, ctrl_act_q;
    chop_cfg_type chop_q;
    logic [5:0] polarity_q;
    logic [7:0] rep_pre_q, rep_cnt_q;
    logic irq_q, cke_prev_q, update_q;
    logic [15:0] cmp_pre_q [NUM_CMP];
    logic [7:0] cmp_lo_q [NUM_CMP];
    logic [12:0] cmp_act_q [NUM_CMP];
    logic [NUM_CMP-1:0] lo_wr, hi_wr;

    logic [2:0] presc_cnt_q;
    logic [11:0] cnt_q;
    cnt_dir_type dir_q;
    logic tick, turn, update, xfer, cke_rise;
    logic [11:0] period;
    logic [12:0] cnt13;
    logic [2:0] phase_q, phase_route_q;
    logic [10:0] chop_cnt_q;
    logic chop_wave_q;
    logic [NUM_CH-1:0] drive_q, drive_d;

    // ---------------- AXI4-Lite slave ----------------
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    assign wr_do = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_en = wr_do & w_strb_q;

    always_comb begin
        wr_hit = 1'b0;
        case (aw_addr_q)
            ADDR_CTRL, ADDR_PWM_CTRL, ADDR_CHOP, ADDR_POLARITY, ADDR_REPEAT,
            ADDR_STATUS: wr_hit = 1'b1;
            default: wr_hit = |{lo_wr, hi_wr} | ((aw_addr_q >= ADDR_CMP_BASE) &&
                (aw_addr_q < ADDR_CMP_BASE + 8'(NUM_CMP) * CMP_STRIDE) &&
                (aw_addr_q[1:0] == 2'b00));
        endcase
    end

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b0;
            aw_addr_q <= BYTE_RESET;
        end else if (awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= awaddr;
        end else begin
            awready_q <= awvalid & ~awready_q & ~aw_held_q;
            if (wr_do) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b0;
            w_data_q <= BYTE_RESET;
            w_strb_q <= 1'b0;
        end else if (wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
        end else begin
            wready_q <= wvalid & ~wready_q & ~w_held_q;
            if (wr_do) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read path; compare offsets return preload, never the active copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
            case (araddr)
                ADDR_CTRL: rdata_q[2:0] <= gen_q;
                ADDR_PWM_CTRL: rdata_q[7:0] <= ctrl_pre_q;
                ADDR_CHOP: rdata_q[4:0] <= chop_q;
                ADDR_POLARITY: rdata_q[5:0] <= polarity_q;
                ADDR_REPEAT: rdata_q[7:0] <= rep_pre_q;
                ADDR_STATUS: rdata_q <= {4'h0, cnt_q, 14'h0000, dir_q == CNT_DOWN, irq_q};
                default: begin
                    if (araddr >= ADDR_CMP_BASE &&
                        araddr < ADDR_CMP_BASE + 8'(NUM_CMP) * CMP_STRIDE &&
                        araddr[1:0] == 2'b00) begin
                        rdata_q[7:0] <= araddr[2] ? cmp_pre_q[araddr[4:3]][15:8] :
                                                    cmp_pre_q[araddr[4:3]][7:0];
                    end else begin
                        rresp_q <= RESP_SLVERR;
                    end
                end
            endcase
        end else begin
            arready_q <= arvalid & ~arready_q & ~rvalid_q;
            if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ---------------- Control registers ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_q <= '0;
            chop_q <= '0;
            polarity_q <= '0;
            rep_pre_q <= BYTE_RESET;
        end else if (wr_en) begin
            case (aw_addr_q)
                ADDR_CTRL: gen_q <= w_data_q[2:0];
                ADDR_CHOP: chop_q <= w_data_q[4:0];
                ADDR_POLARITY: polarity_q <= w_data_q[5:0];
                ADDR_REPEAT: rep_pre_q <= w_data_q;
                default: ;
            endcase
        end
    end

    // Full-duty bits are cleared at update unless rewritten in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_pre_q <= '0;
        end else if (wr_en && aw_addr_q == ADDR_PWM_CTRL) begin
            ctrl_pre_q <= w_data_q;
        end else if (update) begin
            ctrl_pre_q.full_duty_force <= 3'b000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_act_q <= '0;
        end else if (xfer) begin
            ctrl_act_q <= ctrl_pre_q;
        end
    end

    // Compare byte pairs, one generate entry per compare
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        assign lo_wr[i] = wr_en && aw_addr_q == ADDR_CMP_BASE + 8'(i) * CMP_STRIDE;
        assign hi_wr[i] = wr_en && aw_addr_q == ADDR_CMP_BASE + 8'(i) * CMP_STRIDE + CMP_HIGH_OFS;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cmp_lo_q[i] <= BYTE_RESET;
                cmp_pre_q[i] <= (i == 0) ? PERIOD_RESET : CMP_RESET;
            end else if (lo_wr[i] && ctrl_pre_q.byte_mode_sel) begin
                cmp_pre_q[i] <= {BYTE_RESET, w_data_q};
            end else if (lo_wr[i]) begin
                cmp_lo_q[i] <= w_data_q;
            end else if (hi_wr[i] && !ctrl_pre_q.byte_mode_sel) begin
                cmp_pre_q[i] <= {w_data_q, cmp_lo_q[i]};
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cmp_act_q[i] <= round13((i == 0) ? PERIOD_RESET : CMP_RESET);
            end else if (xfer) begin
                cmp_act_q[i] <= ctrl_pre_q.byte_mode_sel ? {5'h00, cmp_pre_q[i][7:0]} :
                                                           round13(cmp_pre_q[i]);
            end
        end
    end

    // ---------------- Counter, prescaler, update ----------------
    // carrier period compare
    assign period = cmp_act_q[0][11:0];
    assign cnt13 = {1'b0, cnt_q};
    assign tick = gen_q.clock_enable && presc_cnt_q == ctrl_act_q.pwm_prescale_sel;
    assign turn = tick && (dir_q == CNT_UP ? cnt_q >= period : cnt_q == '0);
    assign update = turn && rep_cnt_q == '0;
    assign cke_rise = gen_q.clock_enable & ~cke_prev_q;
    assign xfer = update | cke_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn || !gen_q.clock_enable || tick) begin
            presc_cnt_q <= 3'b000;
        end else begin
            presc_cnt_q <= presc_cnt_q + 3'b001;
        end
    end

    // Period zero is not handled; software never programs it
    always_ff @(posedge aclk) begin
        if (!aresetn || !gen_q.clock_enable) begin
            cnt_q <= '0;
            dir_q <= CNT_UP;
        end else if (tick) begin
            case (dir_q)
                CNT_UP: begin
                    if (cnt_q >= period && !ctrl_act_q.center_align_sel) begin
                        cnt_q <= '0;
                    end else if (cnt_q >= period) begin
                        dir_q <= CNT_DOWN;
                        cnt_q <= cnt_q - 12'h001;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                CNT_DOWN: begin
                    if (cnt_q == '0) begin
                        dir_q <= CNT_UP;
                        cnt_q <= 12'h001;
                    end else begin
                        cnt_q <= cnt_q - 12'h001;
                    end
                end
                default: dir_q <= CNT_UP;
            endcase
        end
    end

    // Auto-reload repeat counter, one step per overflow or underflow
    always_ff @(posedge aclk) begin
        if (!aresetn || cke_rise) begin
            rep_cnt_q <= BYTE_RESET;
        end else if (turn) begin
            rep_cnt_q <= (rep_cnt_q == '0) ? rep_pre_q : rep_cnt_q - 8'h01;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
            update_q <= 1'b0;
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= gen_q.clock_enable;
            update_q <= xfer;
            if (xfer) begin
                irq_q <= 1'b1;
            end else if (wr_en && aw_addr_q == ADDR_STATUS && w_data_q[STAT_IRQ_BIT]) begin
                irq_q <= 1'b0;
            end
        end
    end

    // ---------------- Phase compare ----------------
    // three compares one counter
    for (genvar p = 0; p < 3; p++) begin : g_phase
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                phase_q[p] <= 1'b0;
            end else if (ctrl_act_q.byte_mode_sel && ctrl_act_q.full_duty_force[p]) begin
                phase_q[p] <= 1'b1;
            end else if (cmp_act_q[p+1] == '0) begin
                phase_q[p] <= 1'b0;
            end else if (cmp_act_q[p+1] > {1'b0, period}) begin
                phase_q[p] <= 1'b1;
            end else if (ctrl_act_q.center_align_sel && dir_q == CNT_DOWN) begin
                phase_q[p] <= cnt13 <= cmp_act_q[p+1];
            end else begin
                phase_q[p] <= cnt13 < cmp_act_q[p+1];
            end
        end
    end

    // ---------------- Chopper and routing ----------------
    // chop carrier
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chop_cnt_q <= '0;
            chop_wave_q <= 1'b0;
        end else if (chop_cnt_q >= chop_half(chop_q.chop_freq_sel) - 11'd1) begin
            chop_cnt_q <= '0;
            chop_wave_q <= ~chop_wave_q;
        end else begin
            chop_cnt_q <= chop_cnt_q + 11'd1;
        end
    end

    for (genvar k = 0; k < NUM_CH; k++) begin : g_chan
        logic src, lvl, high_side, chop_en;
        assign src = gen_q.phase_count_sel ? phase_q[k/2] : phase_q[0];
        assign lvl = ((k % 2 == 1) && (gen_q.phase_count_sel || gen_q.deadtime_enable_bit)) ?
                     ~src : src;
        assign high_side = (gen_q.phase_count_sel || gen_q.deadtime_enable_bit) ?
                           (k % 2 == 0) : polarity_q[k];
        assign chop_en = high_side ? chop_q.chop_channel_sel[1] : chop_q.chop_channel_sel[0];
        assign drive_d[k] = chop_en ? (lvl & chop_wave_q) : lvl;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_q <= '0;
            phase_route_q <= 3'b000;
        end else begin
            drive_q <= drive_d;
            phase_route_q <= gen_q.phase_count_sel ? phase_q : {2'b00, phase_q[0]};
        end
    end

    assign motor_drive_output = drive_q;
    assign phase_out = phase_route_q;
    assign update_pulse = update_q;

    // ---------------- Assertions ----------------
    property p_cnt_stopped;
        @(posedge aclk) disable iff (!aresetn) !gen_q.clock_enable |=> cnt_q == '0;
    endproperty
    a_cnt_stopped: assert property (p_cnt_stopped) else $error("counter ran while disabled");

    property p_start_xfer;
        @(posedge aclk) disable iff (!aresetn) cke_rise |=> irq_q && update_q;
    endproperty
    a_start_xfer: assert property (p_start_xfer) else $error("start did not transfer");

    property p_active_stable;
        @(posedge aclk) disable iff (!aresetn) !xfer |=> $stable(cmp_act_q[1]) && $stable(period);
    endproperty
    a_active_stable: assert property (p_active_stable) else $error("active compare moved");

    property p_presc_bound;
        @(posedge aclk) disable iff (!aresetn) presc_cnt_q <= ctrl_act_q.pwm_prescale_sel;
    endproperty
    a_presc_bound: assert property (p_presc_bound) else $error("prescaler overran");

    property p_edge_clear;
        @(posedge aclk) disable iff (!aresetn)
            tick && !ctrl_act_q.center_align_sel && cnt_q >= period && gen_q.clock_enable
            ##1 gen_q.clock_enable |-> cnt_q == '0;
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge counter not cleared");

    property p_center_turn;
        @(posedge aclk) disable iff (!aresetn)
            tick && ctrl_act_q.center_align_sel && dir_q == CNT_UP && cnt_q >= period
            ##1 gen_q.clock_enable |-> dir_q == CNT_DOWN;
    endproperty
    a_center_turn: assert property (p_center_turn) else $error("center counter did not turn");

    property p_zero_low;
        @(posedge aclk) disable iff (!aresetn)
            cmp_act_q[1] == '0 && !(ctrl_act_q.byte_mode_sel && ctrl_act_q.full_duty_force[0])
            |=> !phase_q[0];
    endproperty
    a_zero_low: assert property (p_zero_low) else $error("zero compare not low");

    property p_force_clear;
        @(posedge aclk) disable iff (!aresetn)
            update && !(wr_en && aw_addr_q == ADDR_PWM_CTRL) |=> ctrl_pre_q.full_duty_force == '0;
    endproperty
    a_force_clear: assert property (p_force_clear) else $error("full duty not cleared");

    property p_low_only;
        @(posedge aclk) disable iff (!aresetn)
            lo_wr[1] && !ctrl_pre_q.byte_mode_sel |=> $stable(cmp_pre_q[1]);
    endproperty
    a_low_only: assert property (p_low_only) else $error("low byte committed early");

    property p_update_flag;
        @(posedge aclk) disable iff (!aresetn) update |=> irq_q ##1 update_q == 1'b0 || xfer;
    endproperty
    a_update_flag: assert property (p_update_flag) else $error("update flag missing");

endmodule : pwm_chopper_gen

//--- pwm_far_side.sv
// Far-side model: counts update events seen by the channel manager
`timescale 1ns/10ps
module pwm_far_side (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic update_pulse,
    output int updates_q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            updates_q <= 0;
        end else if (update_pulse) begin
            updates_q <= updates_q + 1;
        end
    end
endmodule : pwm_far_side

//--- tb_top.sv
// Self-checking bench for the PWM generator with chopper
`timescale 1ns/10ps
module tb_top;
    import pwm_gen_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_type;
    logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic update_pulse;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got, hu, h0, h1, hx, hl, np;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] phase_out;
    logic [5:0] motor_drive_output;
    int updates_q, fail_count, checked, cycles;
    // Period 8 and phase U compare 4, left-aligned
    // period never zero
    row_type rows [15] = '{
        '{1'b0, 8'h20, 32'hf8, RESP_OKAY}, '{1'b0, 8'h24, 32'hff, RESP_OKAY},
        '{1'b0, 8'h00, 32'h0, RESP_OKAY}, '{1'b0, 8'h18, 32'h0, RESP_SLVERR},
        '{1'b1, 8'h18, 32'h5, RESP_SLVERR}, '{1'b1, 8'h20, 32'h40, RESP_OKAY},
        '{1'b1, 8'h24, 32'h0, RESP_OKAY}, '{1'b1, 8'h28, 32'h20, RESP_OKAY},
        '{1'b1, 8'h2c, 32'h0, RESP_OKAY}, '{1'b1, 8'h04, 32'h0, RESP_OKAY},
        '{1'b0, 8'h20, 32'h40, RESP_OKAY}, '{1'b0, 8'h28, 32'h20, RESP_OKAY},
        '{1'b0, 8'h2c, 32'h0, RESP_OKAY}, '{1'b0, 8'h14, 32'h0, RESP_OKAY},
        '{1'b0, 8'h08, 32'h0, RESP_OKAY}};

    pwm_chopper_gen i_pwm_chopper_gen (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
        .phase_out(phase_out), .motor_drive_output(motor_drive_output),
        .update_pulse(update_pulse));
    pwm_far_side i_pwm_far_side (.aclk(aclk), .aresetn(aresetn),
        .update_pulse(update_pulse), .updates_q(updates_q));

    task automatic tally_and_finish;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Bready is held high, so the answer is taken at the edge it shows
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        got = rdata;
        resp = rresp;
    endtask : rd

    // Window lengths are whole carrier periods, so phase does not matter
    task automatic measure(input int n, input int settle);
        int u0;
        repeat (settle) @(posedge aclk);
        hu = 0;
        h0 = 0;
        h1 = 0;
        hx = 0;
        hl = 0;
        u0 = updates_q;
        repeat (n) begin
            @(posedge aclk);
            hu += phase_out[0];
            h0 += motor_drive_output[0];
            h1 += motor_drive_output[1];
            hx += |phase_out[2:1];
            hl += motor_drive_output[3];
        end
        np = 32'(updates_q - u0);
    endtask : measure

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {fail_count, checked, cycles} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else rd(rows[i].a);
            chk(resp, rows[i].r);
            if (!rows[i].wr && rows[i].r == RESP_OKAY) chk(got, rows[i].d);
        end
        wr(8'h00, 32'h1);
        rd(8'h14);
        chk(got & 32'h1, 32'h1);
        measure(90, 0);
        chk(hu, 32'd40);
        chk(np, 32'd10);
        chk(hx, 32'd0);
        wr(8'h04, 32'h8);
        measure(160, 40);
        chk(hu, 32'd80);
        chk(np, 32'd20);
        wr(8'h04, 32'h1);
        measure(180, 40);
        chk(hu, 32'd80);
        chk(np, 32'd10);
        wr(8'h04, 32'h0);
        wr(8'h28, 32'h0);
        wr(8'h2c, 32'h0);
        measure(90, 40);
        chk(hu, 32'd0);
        wr(8'h28, 32'h48);
        measure(90, 40);
        chk(hu, 32'd0);
        wr(8'h2c, 32'h0);
        measure(90, 40);
        chk(hu, 32'd90);
        wr(8'h00, 32'h3);
        for (int s = 0; s < 4; s++) begin
            wr(8'h08, 32'h1c | 32'(s));
            measure(1240, 10);
            chk(h0, s[1] ? 32'd620 : 32'd1240);
            chk(h1, 32'd0);
            chk(hl, s[0] ? 32'd620 : 32'd1240);
        end
        // Single-phase, side taken from polarity: only channel 0 is high
        wr(8'h00, 32'h1);
        wr(8'h0c, 32'h1);
        wr(8'h08, 32'h1d);
        measure(1240, 10);
        chk(h0, 32'd1240);
        chk(h1, 32'd620);
        // Complementary pairs ignore polarity, even channels are high
        wr(8'h00, 32'h5);
        wr(8'h08, 32'h1e);
        measure(1240, 10);
        chk(h0, 32'd620);
        chk(h1, 32'd0);
        // Mid-run reset must bring outputs and registers back to idle
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'({phase_out, motor_drive_output, update_pulse}), 32'h0);
        rd(8'h24);
        chk(got, 32'hff);
        rd(8'h14);
        chk(got, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
